// ---- rtl/rff_status_flags.sv ----
// Summary of operation
// - Bit n of the not-empty register is high exactly while FIFO n holds one or more messages.
// - Bit n of the threshold register is high while FIFO n holds more messages than the threshold.
// - Bit n of the full register is high while FIFO n holds thirty-two messages.
// - Bit n of the muxed register is the flag picked by channel n's two-bit flag select.
// - All four flag registers are eight bits, bit n belonging to receive channel n.
// - Not-empty, threshold, muxed and full registers are read-only; writes to them are ignored.
// - Select 00 never raises the muxed flag, 01 not-empty, 10 above-threshold, 11 full.
// - After reset every FIFO is empty and the three status registers read zero.
// - The threshold is a five-bit count, 00000 means one or more, 11111 means full, reset 10000.
// - A write to a full FIFO is kept, the oldest message is dropped and full stays set.
`timescale 1ns/1ps
`default_nettype none
module rff_status_flags
    import rff_pkg::*;
#(
    parameter int NCH = RFF_NCH,
    parameter int DEPTH = RFF_DEPTH,
    parameter int THR_W = RFF_THR_W
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [NCH-1:0] fifo_push,
    input wire logic [NCH-1:0] fifo_pop,
    input wire logic [2*NCH-1:0] flag_select,
    input wire logic [RFF_AW-1:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [RFF_DW-1:0] reg_wdata,
    output logic [RFF_DW-1:0] reg_rdata,
    output logic reg_rvalid,
    output logic [NCH-1:0] fifo_nonempty_flags,
    output logic [NCH-1:0] fifo_threshold_flags,
    output logic [NCH-1:0] fifo_full_flags,
    output logic [NCH-1:0] muxed_fifo_flags,
    output logic [NCH-1:0] drop_oldest
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);

    if (NCH < 1 || NCH > RFF_DW || DEPTH != (1 << THR_W) || THR_W != RFF_THR_W) begin : g_bad
        $error("rff_status_flags: unsupported channel count or depth");
    end

    logic [CW-1:0] cnt_reg [NCH];
    logic [CW-1:0] cnt_next [NCH];
    logic [THR_W-1:0] thr_reg;
    logic [THR_W-1:0] thr_next;
    logic [NCH-1:0] nonempty_bit_next;
    logic [NCH-1:0] over_threshold_bit_next;
    logic [NCH-1:0] full_bit_next;
    logic [NCH-1:0] muxed_flag_bit_next;
    logic [RFF_DW-1:0] rdata_next;
    logic rvalid_next;

    function automatic logic [RFF_DW-1:0] rff_pad(input logic [NCH-1:0] v);
        logic [RFF_DW-1:0] r;
        r = '0;
        for (int k = 0; k < NCH; k++) begin
            r[k] = v[k];
        end
        return r;
    endfunction

    function automatic logic rff_pick(input logic [1:0] sel, input logic ne, input logic ov,
                                      input logic fu);
        logic r;
        r = 1'b0;
        case (rff_fsel_t'(sel))
            RFF_FSEL_NEVER: r = 1'b0;
            RFF_FSEL_NONEMPTY: r = ne;
            RFF_FSEL_THRESH: r = ov;
            RFF_FSEL_FULL: r = fu;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // Occupancy counter per channel
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        rff_occ_counter #(
            .DEPTH(DEPTH),
            .CW(CW)
        ) u_cnt (
            .clk(clk),
            .resetn(resetn),
            .push(fifo_push[i]),
            .pop(fifo_pop[i]),
            .count_reg(cnt_reg[i]),
            .count_next(cnt_next[i]),
            .drop_reg(drop_oldest[i])
        );
    end

    always_comb begin
        thr_next = thr_reg;
        if (reg_wr && reg_addr == RFF_ADDR_THR_VALUE) begin
            thr_next = reg_wdata[THR_W-1:0];
        end
        for (int n = 0; n < NCH; n++) begin
            nonempty_bit_next[n] = cnt_next[n] != '0;
            over_threshold_bit_next[n] = cnt_next[n] > CW'(thr_next);
            full_bit_next[n] = cnt_next[n] == FULL_COUNT;
            muxed_flag_bit_next[n] = rff_pick(flag_select[2*n +: 2], nonempty_bit_next[n],
                                              over_threshold_bit_next[n], full_bit_next[n]);
        end
    end

    always_comb begin
        rdata_next = '0;
        rvalid_next = reg_rd;
        // read map, writes to flags ignored
        if (reg_rd) begin
            case (reg_addr)
                RFF_ADDR_MUXED: rdata_next = rff_pad(muxed_fifo_flags);
                RFF_ADDR_FULL: rdata_next = rff_pad(fifo_full_flags);
                RFF_ADDR_THRESH: rdata_next = rff_pad(fifo_threshold_flags);
                RFF_ADDR_NONEMPTY: rdata_next = rff_pad(fifo_nonempty_flags);
                RFF_ADDR_THR_VALUE: rdata_next = RFF_DW'(thr_reg);
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            thr_reg <= RFF_THR_RESET;
            fifo_nonempty_flags <= RFF_FLAGS_RESET[NCH-1:0];
            fifo_threshold_flags <= RFF_FLAGS_RESET[NCH-1:0];
            fifo_full_flags <= RFF_FLAGS_RESET[NCH-1:0];
            muxed_fifo_flags <= RFF_FLAGS_RESET[NCH-1:0];
            reg_rdata <= '0;
            reg_rvalid <= 1'b0;
        end else begin
            thr_reg <= thr_next;
            fifo_nonempty_flags <= nonempty_bit_next;
            fifo_threshold_flags <= over_threshold_bit_next;
            fifo_full_flags <= full_bit_next;
            muxed_fifo_flags <= muxed_flag_bit_next;
            reg_rdata <= rdata_next;
            reg_rvalid <= rvalid_next;
        end
    end

    sequence s_rd_nonempty;
        reg_rd && reg_addr == RFF_ADDR_NONEMPTY;
    endsequence
    sequence s_nonempty_answer;
        reg_rvalid && reg_rdata == rff_pad($past(fifo_nonempty_flags));
    endsequence
    property p_read_nonempty;
        @(posedge clk) disable iff (!resetn)
        s_rd_nonempty |=> s_nonempty_answer;
    endproperty
    AST_READ_NONEMPTY: assert property (p_read_nonempty) else $error("not-empty readback wrong");

    property p_full_write_ignored;
        @(posedge clk) disable iff (!resetn)
        (reg_wr && reg_addr == RFF_ADDR_FULL && fifo_push == '0 && fifo_pop == '0)
            |=> $stable(fifo_full_flags);
    endproperty
    AST_FULL_WRITE: assert property (p_full_write_ignored) else $error("full flags moved on write");

    property p_reset_flags;
        @(posedge clk) disable iff (1'b0)
        !resetn |=> (fifo_nonempty_flags == '0 && fifo_threshold_flags == '0
                     && fifo_full_flags == '0);
    endproperty
    AST_RESET_FLAGS: assert property (p_reset_flags) else $error("flags not cleared by reset");

    property p_reset_thr;
        @(posedge clk) disable iff (1'b0)
        !resetn |=> thr_reg == RFF_THR_RESET;
    endproperty
    AST_RESET_THR: assert property (p_reset_thr) else $error("threshold default wrong");

    for (genvar j = 0; j < NCH; j++) begin : g_chk
        AST_NONEMPTY: assert property (@(posedge clk) disable iff (!resetn)
            fifo_nonempty_flags[j] == (cnt_reg[j] != '0)) else $error("not-empty flag wrong");
        AST_THRESH: assert property (@(posedge clk) disable iff (!resetn)
            fifo_threshold_flags[j] == (cnt_reg[j] > CW'(thr_reg)))
            else $error("threshold flag wrong");
        AST_FULL: assert property (@(posedge clk) disable iff (!resetn)
            fifo_full_flags[j] == (cnt_reg[j] == FULL_COUNT)) else $error("full flag wrong");
        AST_MUX: assert property (@(posedge clk) disable iff (!resetn)
            ##1 muxed_fifo_flags[j] == rff_pick($past(flag_select[2*j +: 2]),
                fifo_nonempty_flags[j], fifo_threshold_flags[j], fifo_full_flags[j]))
            else $error("muxed flag wrong");
        AST_MUX_NEVER: assert property (@(posedge clk) disable iff (!resetn)
            flag_select[2*j +: 2] == RFF_FSEL_NEVER |=> !muxed_fifo_flags[j])
            else $error("muxed flag raised with select 00");

        sequence s_push_full;
            cnt_reg[j] == FULL_COUNT && fifo_push[j] && !fifo_pop[j];
        endsequence
        AST_OVERWRITE: assert property (@(posedge clk) disable iff (!resetn)
            s_push_full |=> (drop_oldest[j] && fifo_full_flags[j] && cnt_reg[j] == FULL_COUNT))
            else $error("full push not handled");

        sequence s_push_empty;
            cnt_reg[j] == '0 && fifo_push[j];
        endsequence
        AST_SAME_CYCLE: assert property (@(posedge clk) disable iff (!resetn)
            s_push_empty |=> (fifo_nonempty_flags[j] && cnt_reg[j] == CW'(1)))
            else $error("not-empty late after first push");
    end
endmodule
`default_nettype wire

// ---- rtl/rff_pkg.sv ----
package rff_pkg;
    // Channel and FIFO geometry
    localparam int RFF_NCH = 8;
    localparam int RFF_DEPTH = 32;
    localparam int RFF_THR_W = 5;
    localparam int RFF_DW = 8;
    localparam int RFF_AW = 16;
    // Register addresses on the host port
    localparam logic [15:0] RFF_ADDR_MUXED = 16'h800c;
    localparam logic [15:0] RFF_ADDR_THR_VALUE = 16'h8028;
    localparam logic [15:0] RFF_ADDR_FULL = 16'h8029;
    localparam logic [15:0] RFF_ADDR_THRESH = 16'h802a;
    localparam logic [15:0] RFF_ADDR_NONEMPTY = 16'h802b;
    // Reset values
    localparam logic [7:0] RFF_FLAGS_RESET = 8'h00;
    localparam logic [4:0] RFF_THR_RESET = 5'h10;
    // Flag select encoding
    typedef enum logic [1:0] {
        RFF_FSEL_NEVER = 2'b00,
        RFF_FSEL_NONEMPTY = 2'b01,
        RFF_FSEL_THRESH = 2'b10,
        RFF_FSEL_FULL = 2'b11
    } rff_fsel_t;
endpackage

// ---- rtl/rff_occ_counter.sv ----
`timescale 1ns/1ps
`default_nettype none
module rff_occ_counter
    import rff_pkg::*;
#(
    parameter int DEPTH = RFF_DEPTH,
    parameter int CW = $clog2(DEPTH + 1)
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic push,
    input wire logic pop,
    output logic [CW-1:0] count_reg,
    output logic [CW-1:0] count_next,
    output logic drop_reg
);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    logic drop_next;

    if (DEPTH < 1 || CW < $clog2(DEPTH + 1)) begin : g_bad
        $error("rff_occ_counter: count width too small for depth");
    end

    always_comb begin
        count_next = count_reg;
        drop_next = 1'b0;
        if (push && !pop) begin
            if (count_reg == FULL_COUNT) begin
                drop_next = 1'b1;
            end else begin
                count_next = count_reg + CW'(1);
            end
        end else if (pop && !push) begin
            if (count_reg != '0) begin
                count_next = count_reg - CW'(1);
            end
        end else if (push && pop && count_reg == '0) begin
            count_next = CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            count_reg <= '0;
            drop_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            drop_reg <= drop_next;
        end
    end

    property p_pop_empty;
        @(posedge clk) disable iff (!resetn)
        (count_reg == '0 && pop && !push) |=> (count_reg == '0 && !drop_reg);
    endproperty
    AST_POP_EMPTY: assert property (p_pop_empty) else $error("pop on empty changed count");
endmodule
`default_nettype wire

// ---- verif/rff_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module rff_host_model
    import rff_pkg::*;
(
    input wire logic clk,
    output logic [RFF_AW-1:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [RFF_DW-1:0] reg_wdata,
    input wire logic [RFF_DW-1:0] reg_rdata,
    input wire logic reg_rvalid
);
    initial begin
        reg_addr = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // One-cycle write strobe, then scramble the idle bus
    task automatic wr(input logic [RFF_AW-1:0] a, input logic [RFF_DW-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    // One-cycle read strobe, answer taken one edge after the edge that samples it
    task automatic rd(input logic [RFF_AW-1:0] a, output logic [RFF_DW-1:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk);
            if (reg_rvalid === 1'b1) begin
                ok = 1'b1;
                d = reg_rdata;
            end
        end
    endtask
endmodule
`default_nettype wire

// ---- verif/rff_status_flags_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module rff_status_flags_tb
    import rff_pkg::*;
;
    typedef struct {int ch; int tgt; logic [4:0] thr; logic [2:0] exp;} rff_row_t;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] fifo_push = 8'h00;
    logic [7:0] fifo_pop = 8'h00;
    logic [15:0] flag_select = 16'h0000;
    logic [15:0] reg_addr;
    logic reg_wr, reg_rd, reg_rvalid;
    logic [7:0] reg_wdata, reg_rdata, drop;
    logic [7:0] fifo_nonempty_flags, fifo_threshold_flags, fifo_full_flags, muxed_fifo_flags;
    int miscompares = 0;
    int comparisons = 0;
    int cnt [8] = '{default: 0};
    logic [15:0] fa [4] = '{RFF_ADDR_MUXED, RFF_ADDR_FULL, RFF_ADDR_THRESH, RFF_ADDR_NONEMPTY};
    // Row: channel, target count, threshold, expected {nonempty, threshold, full}
    rff_row_t rows [8] = '{'{0, 1, 5'h00, 3'b110}, '{0, 0, 5'h00, 3'b000},
        '{1, 16, 5'h10, 3'b100}, '{1, 17, 5'h10, 3'b110}, '{2, 31, 5'h1f, 3'b100},
        '{2, 32, 5'h1f, 3'b111}, '{3, 32, 5'h10, 3'b111}, '{7, 2, 5'h01, 3'b110}};
    always #5 clk = ~clk;
    rff_status_flags rff_status_flags_i (.clk, .resetn, .fifo_push, .fifo_pop, .flag_select,
        .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid, .fifo_nonempty_flags,
        .fifo_threshold_flags, .fifo_full_flags, .muxed_fifo_flags, .drop_oldest(drop));
    rff_host_model rff_host_model_i (.clk, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .reg_rvalid);
    task automatic end_of_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] exp);
        logic [7:0] d;
        logic ok;
        rff_host_model_i.rd(a, d, ok);
        if (ok !== 1'b1) begin
            miscompares++;
            $display("mismatch at %0t: no read answer", $time);
            end_of_test();
        end
        check(d, exp);
    endtask
    // Expected register from the count model: 0 nonempty, 1 threshold, 2 full, 3 muxed
    function automatic logic [7:0] want(input int kind, input logic [4:0] t);
        logic [2:0] f;
        logic [1:0] s;
        for (int n = 0; n < 8; n++) begin
            f = {cnt[n] == 32, cnt[n] > t, cnt[n] != 0};
            s = flag_select[2*n +: 2];
            want[n] = kind < 3 ? f[kind] : (s != 2'b00 && f[s - 1]);
        end
    endfunction
    task automatic move(input int ch, input int tgt);
        int k;
        k = tgt - cnt[ch];
        if (k != 0) begin
            @(posedge clk);
            if (k > 0) fifo_push[ch] <= 1'b1;
            else fifo_pop[ch] <= 1'b1;
            repeat (k > 0 ? k : -k) @(posedge clk);
            fifo_push[ch] <= 1'b0;
            fifo_pop[ch] <= 1'b0;
            cnt[ch] = tgt;
        end
    endtask
    task automatic do_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        cnt = '{default: 0};
        foreach (fa[i]) rdchk(fa[i], RFF_FLAGS_RESET);
        rdchk(RFF_ADDR_THR_VALUE, {3'b000, RFF_THR_RESET});
    endtask
    initial begin
        int ch;
        do_reset();
        foreach (rows[r]) begin
            ch = rows[r].ch;
            rff_host_model_i.wr(RFF_ADDR_THR_VALUE, {3'b000, rows[r].thr});
            move(ch, rows[r].tgt);
            for (int s = 0; s < 4; s++) begin
                @(posedge clk);
                flag_select[2*ch +: 2] <= s[1:0];
                repeat (2) @(posedge clk);
                #1;
                check({7'h00, muxed_fifo_flags[ch]}, {7'h00, s != 0 && rows[r].exp[3 - s]});
            end
            check({7'h00, fifo_nonempty_flags[ch]}, {7'h00, rows[r].exp[2]});
            check({7'h00, fifo_threshold_flags[ch]}, {7'h00, rows[r].exp[1]});
            check({7'h00, fifo_full_flags[ch]}, {7'h00, rows[r].exp[0]});
            for (int i = 0; i < 4; i++) rdchk(fa[i], want(3 - i, rows[r].thr));
        end
        @(posedge clk);
        fifo_push <= 8'h24;
        fifo_pop <= 8'h50;
        @(posedge clk);
        fifo_push <= 8'h00;
        fifo_pop <= 8'h00;
        cnt[5] = 1;
        #1;
        check(drop, 8'h04);
        check(fifo_full_flags, 8'h0c);
        check(fifo_nonempty_flags, 8'hae);
        @(posedge clk);
        fifo_push <= 8'h40;
        fifo_pop <= 8'h60;
        @(posedge clk);
        fifo_push <= 8'h00;
        fifo_pop <= 8'h00;
        cnt[5] = 0;
        cnt[6] = 1;
        #1;
        check(drop, 8'h00);
        check(fifo_nonempty_flags, 8'hce);
        foreach (fa[i]) rff_host_model_i.wr(fa[i], 8'hff);
        rff_host_model_i.wr(RFF_ADDR_THR_VALUE, 8'hff);
        for (int i = 0; i < 4; i++) rdchk(fa[i], want(3 - i, 5'h1f));
        rdchk(RFF_ADDR_THR_VALUE, 8'h1f);
        rdchk(16'h8000, 8'h00);
        do_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
